// [rtl/rps_top.sv]
// remappable pin select: input and output routing with lockable registers
`timescale 1ns/1ns
`default_nettype none
module rps_top #(
    parameter bit HAS_OUT12 = 1'b1
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // register port
    input  wire logic [5:0]  bus_addr,
    input  wire logic [15:0] bus_wdata,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    output logic      [15:0] bus_rdata,
    // pins
    input  wire logic [25:0] pin_in,
    output logic      [25:0] pin_out,
    output logic      [25:0] pin_remap_en,
    // peripherals
    input  wire logic [31:0] periph_func_out,
    output logic      [31:0] periph_in,
    output logic             ext_irq1_in,
    output logic             uart_a_rx_in,
    output logic             uart_a_cts_in,
    output logic             uart_b_rx_in,
    output logic             uart_b_cts_in,
    output logic             pin_cfg_lock
);

////////////////////////////////////////////////////////////////////////////////
// storage
logic [31:0][4:0] in_fld_reg;
logic [31:0][4:0] in_fld_next;
logic [25:0][4:0] out_fld_reg;
logic [25:0][4:0] out_fld_next;
logic             lock_reg;
logic             lock_next;
logic [25:0]      sync1_reg;
logic [25:0]      sync2_reg;
logic [25:0]      sync3_reg;
logic [25:0]      pin_filt_reg;
logic [25:0]      pin_filt_next;
logic [31:0]      periph_in_reg;
logic [31:0]      periph_in_next;
logic [25:0]      pin_out_reg;
logic [25:0]      pin_out_next;
logic [25:0]      pin_en_reg;
logic [25:0]      pin_en_next;
logic [15:0]      rdata_reg;
logic [15:0]      rdata_next;

////////////////////////////////////////////////////////////////////////////////
// address decode
wire [5:0]  out_off   = bus_addr - rps_pkg::OUT_BASE;
wire [3:0]  in_idx    = bus_addr[3:0];
wire [3:0]  out_idx   = out_off[3:0];
wire [5:0]  out_cnt   = HAS_OUT12 ? rps_pkg::OUT_CNT_FULL
                                  : rps_pkg::OUT_CNT_SMALL; // see [R9]
wire        in_hit    = (bus_addr >= rps_pkg::IN_BASE) &&
                        (bus_addr < rps_pkg::OUT_BASE);
wire        out_hit   = (bus_addr >= rps_pkg::OUT_BASE) &&
                        (out_off < out_cnt);
wire        lock_hit  = (bus_addr == rps_pkg::LOCK_ADDR);
wire        plo_hit   = (bus_addr == rps_pkg::PIN_LO_ADDR);
wire        phi_hit   = (bus_addr == rps_pkg::PIN_HI_ADDR);
wire        wr_in     = bus_wr && in_hit && !lock_reg;  // see [R2]
wire        wr_out    = bus_wr && out_hit && !lock_reg; // see [R2]
wire [4:0]  wd_lo     = bus_wdata[rps_pkg::LO_LSB +: rps_pkg::FLD_W];
wire [4:0]  wd_hi     = bus_wdata[rps_pkg::HI_LSB +: rps_pkg::FLD_W];

////////////////////////////////////////////////////////////////////////////////
// register write and read
assign lock_next = (bus_wr && lock_hit) ? bus_wdata[rps_pkg::LOCK_BIT]
                                        : lock_reg;

// only the two five-bit fields are stored; other bits read zero
wire [15:0] in_word  = {3'h0, in_fld_reg[{in_idx, 1'b1}],
                        3'h0, in_fld_reg[{in_idx, 1'b0}]};     // see [R8]
wire [15:0] out_word = {3'h0, out_fld_reg[{out_idx, 1'b1}],
                        3'h0, out_fld_reg[{out_idx, 1'b0}]};   // see [R8]
wire [15:0] rd_word  = in_hit   ? in_word :
                       out_hit  ? out_word :
                       lock_hit ? {15'h0000, lock_reg} :
                       plo_hit  ? pin_filt_reg[15:0] :
                       phi_hit  ? {6'h00, pin_filt_reg[25:16]} :
                       16'h0000;
assign rdata_next = bus_rd ? rd_word : 16'h0000;

genvar gi;
generate
    for (gi = 0; gi < rps_pkg::NUM_IN_FLDS; gi = gi + 1) begin : g_in_fld
        localparam logic [3:0] RIDX = 4'(gi / 2);
        localparam bit         HI   = (gi % 2) == 1;
        // sixteen input registers, two fields each; see [R1]
        assign in_fld_next[gi] = (wr_in && in_idx == RIDX) ?
                                 (HI ? wd_hi : wd_lo) : in_fld_reg[gi];
    end
    for (gi = 0; gi < rps_pkg::NUM_PINS; gi = gi + 1) begin : g_out_fld
        localparam logic [3:0] RIDX  = 4'(gi / 2);
        localparam bit         HI    = (gi % 2) == 1;
        localparam bit         AVAIL = (gi < 24) || HAS_OUT12;
        // pins 24 and 25 share register 12; see [R6] [R7] [R9]
        assign out_fld_next[gi] = (AVAIL && wr_out && out_idx == RIDX) ?
                                  (HI ? wd_hi : wd_lo) : out_fld_reg[gi];
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// pin input filter: change taken once stages two and three agree
wire [25:0] sync_agree = ~(sync2_reg ^ sync3_reg);
assign pin_filt_next = (sync_agree & sync3_reg) |
                       (~sync_agree & pin_filt_reg);
wire [31:0] pin_ext  = {6'h00, pin_filt_reg};
wire [31:0] func_ext = {periph_func_out[31:1], 1'b0};

////////////////////////////////////////////////////////////////////////////////
// routing
generate
    for (gi = 0; gi < rps_pkg::NUM_IN_FLDS; gi = gi + 1) begin : g_in_route
        // pin n for codes 0..25, ground for all ones; see [R3] [R4] [R5]
        assign periph_in_next[gi] = (in_fld_reg[gi] == rps_pkg::GND_SEL) ?
                                    1'b0 : pin_ext[in_fld_reg[gi]];
    end
    for (gi = 0; gi < rps_pkg::NUM_PINS; gi = gi + 1) begin : g_out_route
        wire sel_any = (out_fld_reg[gi] != rps_pkg::NO_FUNC);
        // code zero releases the pin to port control; see [R10]
        assign pin_en_next[gi]  = sel_any;
        assign pin_out_next[gi] = sel_any & func_ext[out_fld_reg[gi]];
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// flip-flops
always_ff @(posedge clk_sys) begin
    if (srst) begin
        in_fld_reg    <= {rps_pkg::NUM_IN_FLDS{rps_pkg::IN_FLD_RST}};
        out_fld_reg   <= {rps_pkg::NUM_PINS{rps_pkg::OUT_FLD_RST}};
        lock_reg      <= rps_pkg::LOCK_RST;
        rdata_reg     <= 16'h0000;
    end else begin
        in_fld_reg    <= in_fld_next;
        out_fld_reg   <= out_fld_next;
        lock_reg      <= lock_next;
        rdata_reg     <= rdata_next;
    end
end

always_ff @(posedge clk_sys) begin
    if (srst) begin
        sync1_reg     <= 26'h0000000;
        sync2_reg     <= 26'h0000000;
        sync3_reg     <= 26'h0000000;
        pin_filt_reg  <= 26'h0000000;
    end else begin
        sync1_reg     <= pin_in;
        sync2_reg     <= sync1_reg;
        sync3_reg     <= sync2_reg;
        pin_filt_reg  <= pin_filt_next;
    end
end

always_ff @(posedge clk_sys) begin
    if (srst) begin
        periph_in_reg <= 32'h00000000;
        pin_out_reg   <= 26'h0000000;
        pin_en_reg    <= 26'h0000000;
    end else begin
        periph_in_reg <= periph_in_next;
        pin_out_reg   <= pin_out_next;
        pin_en_reg    <= pin_en_next;
    end
end

////////////////////////////////////////////////////////////////////////////////
// outputs
assign bus_rdata     = rdata_reg;
assign pin_out       = pin_out_reg;
assign pin_remap_en  = pin_en_reg;
assign periph_in     = periph_in_reg;
assign ext_irq1_in   = periph_in_reg[rps_pkg::EXT_IRQ1_SLOT];
assign uart_a_rx_in  = periph_in_reg[rps_pkg::UART_A_RX_SLOT];
assign uart_a_cts_in = periph_in_reg[rps_pkg::UART_A_CTS_SLOT];
assign uart_b_rx_in  = periph_in_reg[rps_pkg::UART_B_RX_SLOT];
assign uart_b_cts_in = periph_in_reg[rps_pkg::UART_B_CTS_SLOT];
assign pin_cfg_lock  = lock_reg;

////////////////////////////////////////////////////////////////////////////////
// checks
a_out_reg_count: assert property ( // see [R1]
    @(posedge clk_sys) disable iff (srst)
    bus_rd && bus_addr == 6'h1b |=> bus_rdata[4:0] == $past(out_fld_reg[22]))
    else $error("output register 11 does not read back");

a_lock_drops_wr: assert property ( // see [R2]
    @(posedge clk_sys) disable iff (srst)
    bus_wr && lock_reg && bus_addr < 6'h20 |=>
        $stable(in_fld_reg) && $stable(out_fld_reg))
    else $error("remap register changed while locked");

a_wr_read_back: assert property ( // see [R2]
    @(posedge clk_sys) disable iff (srst)
    (bus_wr && !lock_reg && bus_addr == 6'h03) ##1
    (bus_rd && bus_addr == 6'h03) |=>
        bus_rdata[12:8] == $past(bus_wdata[12:8], 2))
    else $error("unlocked write lost");

a_pin_route: assert property ( // see [R3]
    @(posedge clk_sys) disable iff (srst)
    in_fld_reg[14] <= 5'h19 |=>
        periph_in_reg[14] == $past(pin_filt_reg[in_fld_reg[14]]))
    else $error("input not taken from selected pin");

a_ground_sel: assert property ( // see [R4]
    @(posedge clk_sys) disable iff (srst)
    in_fld_reg[0] == 5'h1f ##1 in_fld_reg[0] == 5'h1f |=>
        periph_in_reg[0] == 1'b0 && $past(periph_in_reg[0]) == 1'b0)
    else $error("ground selection not low");

a_ext_irq1_sel: assert property ( // see [R5]
    @(posedge clk_sys) disable iff (srst)
    (bus_wr && !lock_reg && bus_addr == 6'h00) |=>
        in_fld_reg[1] == $past(bus_wdata[12:8]) ##1
        ext_irq1_in == $past(pin_ext[in_fld_reg[1]]))
    else $error("external interrupt 1 pin select wrong");

a_pin25_func: assert property ( // see [R6]
    @(posedge clk_sys) disable iff (srst)
    out_fld_reg[25] != 5'h00 |=>
        pin_en_reg[25] && pin_out_reg[25] ==
        $past(periph_func_out[out_fld_reg[25]]))
    else $error("pin 25 not driven by selected function");

a_pin24_func: assert property ( // see [R7]
    @(posedge clk_sys) disable iff (srst)
    (bus_wr && !lock_reg && bus_addr == 6'h1c && HAS_OUT12) |=>
        out_fld_reg[24] == $past(bus_wdata[4:0]))
    else $error("pin 24 select not written from low field");

a_unimpl_zero: assert property ( // see [R8]
    @(posedge clk_sys) disable iff (srst)
    bus_rd && bus_addr < 6'h20 |=>
        bus_rdata[15:13] == 3'h0 && bus_rdata[7:5] == 3'h0)
    else $error("unimplemented bits read nonzero");

a_small_pkg: assert property ( // see [R9]
    @(posedge clk_sys) disable iff (srst)
    !HAS_OUT12 |-> out_fld_reg[24] == 5'h00 && out_fld_reg[25] == 5'h00 &&
        !pin_en_reg[24] && !pin_en_reg[25])
    else $error("register 12 active in small package");

a_idle_pin: assert property ( // see [R10]
    @(posedge clk_sys) disable iff (srst)
    out_fld_reg[3] == 5'h00 |=> !pin_en_reg[3] && !pin_out_reg[3])
    else $error("pin driven with no function selected");

a_filter_hold: assert property ( // see [R3]
    @(posedge clk_sys) disable iff (srst)
    sync2_reg[7] != sync3_reg[7] |=>
        pin_filt_reg[7] == $past(pin_filt_reg[7]))
    else $error("pin filter took a change before stages agreed");

a_filter_take: assert property ( // see [R3]
    @(posedge clk_sys) disable iff (srst)
    sync2_reg[7] == sync3_reg[7] |=>
        pin_filt_reg[7] == $past(sync3_reg[7]))
    else $error("pin filter missed an agreed change");

a_lock_write: assert property ( // see [R2]
    @(posedge clk_sys) disable iff (srst)
    bus_wr && bus_addr == 6'h20 |=> lock_reg == $past(bus_wdata[0]))
    else $error("lock bit not written");

a_spare_codes: assert property ( // see [R4]
    @(posedge clk_sys) disable iff (srst)
    in_fld_reg[20] > 5'h19 |=> periph_in_reg[20] == 1'b0)
    else $error("spare input code did not give a low");

a_rdata_idle: assert property ( // see [R8]
    @(posedge clk_sys) disable iff (srst)
    !bus_rd |=> bus_rdata == 16'h0000)
    else $error("read data not zero outside a read");

a_in_reg15_wr: assert property ( // see [R1]
    @(posedge clk_sys) disable iff (srst)
    bus_wr && !lock_reg && bus_addr == 6'h0f |=>
        in_fld_reg[31] == $past(bus_wdata[12:8]))
    else $error("input register 15 not written");

a_pin24_drive: assert property ( // see [R7]
    @(posedge clk_sys) disable iff (srst)
    out_fld_reg[24] != 5'h00 |=>
        pin_en_reg[24] && pin_out_reg[24] ==
        $past(periph_func_out[out_fld_reg[24]]))
    else $error("pin 24 not driven by selected function");

a_pin_readback: assert property ( // see [R8]
    @(posedge clk_sys) disable iff (srst)
    bus_rd && bus_addr == 6'h22 |=> bus_rdata[15:10] == 6'h00)
    else $error("pin level word has nonzero upper bits");

endmodule
`default_nettype wire

// [rtl/rps_pkg.sv]
// constants for the remappable pin select block
// Notes on behaviour
// [R1] Sixteen input-select and thirteen output-select registers exist.
// [R2] Writes to any remap register are dropped while the config lock is set.
// [R3] Input field value n (0..25) feeds the peripheral input from pin n.
// [R4] Input field value all ones feeds the peripheral input a constant low.
// [R5] Bits 12..8 of input register 0 pick the external interrupt 1 pin.
// [R6] Bits 12..8 of output register 12 pick the function driving pin 25.
// [R7] Bits 4..0 of output register 12 pick the function driving pin 24.
// [R8] Unimplemented remap register bits read zero and ignore writes.
// [R9] Output register 12 exists only in the large package variant.
// [R10] Output field value zero leaves the pin to ordinary port control.
package rps_pkg;
    // sizes
    localparam int NUM_IN_REGS  = 16;
    localparam int NUM_OUT_REGS = 13;
    localparam int NUM_IN_FLDS  = 32;
    localparam int NUM_PINS     = 26;
    localparam int NUM_FUNCS    = 32;
    localparam int FLD_W        = 5;
    localparam int ADDR_W       = 6;
    localparam int DATA_W       = 16;
    // field positions
    localparam int LO_LSB   = 0;
    localparam int HI_LSB   = 8;
    localparam int LOCK_BIT = 0;
    // register offsets (word index)
    localparam logic [5:0] IN_BASE      = 6'h00;
    localparam logic [5:0] OUT_BASE     = 6'h10;
    localparam logic [5:0] LOCK_ADDR    = 6'h20;
    localparam logic [5:0] PIN_LO_ADDR  = 6'h21;
    localparam logic [5:0] PIN_HI_ADDR  = 6'h22;
    localparam logic [5:0] OUT_CNT_FULL = 6'h0d;
    localparam logic [5:0] OUT_CNT_SMALL = 6'h0c;
    // reset values and codes
    localparam logic [4:0] IN_FLD_RST  = 5'h1f;
    localparam logic [4:0] OUT_FLD_RST = 5'h00;
    localparam logic       LOCK_RST    = 1'b0;
    localparam logic [4:0] GND_SEL     = 5'h1f;
    localparam logic [4:0] MAX_PIN_SEL = 5'h19;
    localparam logic [4:0] NO_FUNC     = 5'h00;
    // peripheral input slots (field index = 2*register + high half)
    localparam int EXT_IRQ1_SLOT   = 1;
    localparam int UART_A_RX_SLOT  = 14;
    localparam int UART_A_CTS_SLOT = 15;
    localparam int UART_B_RX_SLOT  = 16;
    localparam int UART_B_CTS_SLOT = 17;
endpackage

// [verif/rps_far_end.sv]
// far side model: package pins and peripheral output functions
`timescale 1ns/1ns
`default_nettype none
module rps_far_end (
    // levels set by the bench
    input  wire logic [25:0] ext_lvl,
    input  wire logic [31:0] func_lvl,
    // block side
    input  wire logic [25:0] pin_out,
    input  wire logic [25:0] pin_remap_en,
    output logic      [25:0] pin_in,
    output logic      [31:0] periph_func_out
);
    // a remapped pin reads back its own drive, else the port level
    assign pin_in = (pin_remap_en & pin_out)
                  | (~pin_remap_en & ext_lvl);
    // function 0 does not exist
    assign periph_func_out = {func_lvl[31:1], 1'b0};
endmodule
`default_nettype wire

// [verif/remappable_pin_select_tb.sv]
// self-checking bench for the remappable pin select block
`timescale 1ns/1ns
`default_nettype none
module remappable_pin_select_tb;
    logic        clk_sys = 1'b0;
    logic        srst    = 1'b1;
    logic [5:0]  bus_addr;
    logic [15:0] bus_wdata, bus_rdata, d;
    logic        bus_wr, bus_rd, ext_irq1_in, pin_cfg_lock;
    logic [25:0] pin_in, pin_out, pin_remap_en, ext_lvl;
    logic [31:0] periph_func_out, periph_in, func_lvl, seed;
    logic [4:0]  code, f24, f25;
    int          fails = 0;
    int          check_count = 0;
    logic [15:0] bus_rdata_s, wv;
    logic [25:0] pin_remap_en_s;
    logic        uart_a_rx_in, uart_a_cts_in, uart_b_rx_in, uart_b_cts_in;
    logic        exp_bit;
    int          slot;

    always #20 clk_sys = ~clk_sys;

    rps_top dut (.clk_sys(clk_sys), .srst(srst), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .pin_in(pin_in), .pin_out(pin_out),
        .pin_remap_en(pin_remap_en), .periph_func_out(periph_func_out),
        .periph_in(periph_in), .ext_irq1_in(ext_irq1_in),
        .uart_a_rx_in(uart_a_rx_in), .uart_a_cts_in(uart_a_cts_in),
        .uart_b_rx_in(uart_b_rx_in), .uart_b_cts_in(uart_b_cts_in),
        .pin_cfg_lock(pin_cfg_lock));
    rps_top #(.HAS_OUT12(1'b0)) dut_small (.clk_sys(clk_sys), .srst(srst),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata_s), .pin_in(pin_in),
        .pin_out(), .pin_remap_en(pin_remap_en_s),
        .periph_func_out(periph_func_out), .periph_in(), .ext_irq1_in(),
        .uart_a_rx_in(), .uart_a_cts_in(), .uart_b_rx_in(),
        .uart_b_cts_in(), .pin_cfg_lock());
    rps_far_end far (.ext_lvl(ext_lvl), .func_lvl(func_lvl),
        .pin_out(pin_out), .pin_remap_en(pin_remap_en), .pin_in(pin_in),
        .periph_func_out(periph_func_out));

    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // pin level for codes 0..25, low for every other code
    function automatic logic exp_route(logic [4:0] c, logic [25:0] lvl);
        return (c <= 5'h19) ? lvl[c] : 1'b0;
    endfunction

    // function level on the pin, released for code zero
    function automatic logic exp_drive(logic [4:0] f, logic [31:0] lvl);
        return (f != 5'h00) && lvl[f];
    endfunction

    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(logic [5:0] a, logic [15:0] v);
        @(posedge clk_sys);
        bus_wr    <= 1'b1;
        bus_addr  <= a;
        bus_wdata <= v;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask

    task automatic rd(logic [5:0] a, output logic [15:0] v);
        @(posedge clk_sys);
        bus_rd   <= 1'b1;
        bus_addr <= a;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1 v = bus_rdata;
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        fails++;
        report_and_stop();
    end

    initial begin
        seed      = 32'hb3e7;
        bus_addr  = 6'h00;
        bus_wdata = 16'h0000;
        bus_wr    = 1'b0;
        bus_rd    = 1'b0;
        ext_lvl   = 26'h0000000;
        func_lvl  = 32'h00000000;
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        rd(6'h00, d);
        chk("in_reg0_rst", d, 16'h1f1f);
        @(posedge clk_sys);
        #1 chk("rdata_idle", bus_rdata, 16'h0000);
        rd(6'h1c, d);
        chk("out_reg12_rst", d, 16'h0000);
        rd(6'h20, d);
        chk("lock_rst", d, 16'h0000);
        chk("irq1_gnd", ext_irq1_in, 32'h0);
        for (int i = 0; i < 12; i++) begin
            ext_lvl <= 26'(rnd());
            slot = (i < 4) ? 1 : int'(rnd() % 32);
            code = (i == 0) ? 5'h00 : (i == 1) ? 5'h19 :
                   (i == 2) ? 5'h1f : (i == 3) ? 5'h1a : 5'(rnd() % 26);
            wr(6'(slot / 2), slot[0] ? {3'h0, code, 8'h00} : {11'h0, code});
            repeat (8) @(posedge clk_sys);
            #1;
            exp_bit = exp_route(code, ext_lvl);
            chk("periph_in", periph_in[slot], exp_bit);
            if (slot == 1)
                chk("irq1", ext_irq1_in, exp_bit);
        end
        ext_lvl <= 26'(rnd());
        wr(6'h07, {3'h0, 5'h02, 3'h0, 5'h18});
        wr(6'h08, {3'h0, 5'h1f, 3'h0, 5'h0b});
        repeat (8) @(posedge clk_sys);
        #1;
        exp_bit = exp_route(5'h18, ext_lvl);
        chk("uart_a_rx", uart_a_rx_in, exp_bit);
        exp_bit = exp_route(5'h02, ext_lvl);
        chk("uart_a_cts", uart_a_cts_in, exp_bit);
        exp_bit = exp_route(5'h0b, ext_lvl);
        chk("uart_b_rx", uart_b_rx_in, exp_bit);
        chk("uart_b_cts", uart_b_cts_in, 32'h0);
        rd(6'h21, d);
        chk("pins_lo", d, ext_lvl[15:0]);
        rd(6'h22, d);
        chk("pins_hi", d, {6'h00, ext_lvl[25:16]});
        for (int i = 0; i < 8; i++) begin
            f24 = (i == 0) ? 5'h00 : 5'(rnd());
            f25 = (i == 1) ? 5'h00 : 5'(rnd());
            func_lvl <= rnd();
            wr(6'h1c, {3'h0, f25, 3'h0, f24});
            repeat (4) @(posedge clk_sys);
            #1;
            chk("pin24", pin_out[24], exp_drive(f24, func_lvl));
            chk("pin25", pin_out[25], exp_drive(f25, func_lvl));
            chk("remap_en", pin_remap_en[25:24], {|f25, |f24});
            chk("small_en", pin_remap_en_s[25:24], 2'b00);
        end
        for (int a = 0; a < 29; a++) begin
            wv = 16'(rnd());
            wr(6'(a), wv);
            rd(6'(a), d);
            chk("reg_rw", d, wv & 16'h1f1f);
            chk("reg_unimpl", d & 16'he0e0, 16'h0000);
            if (a == 28)
                chk("small_reg12", bus_rdata_s, 16'h0000);
        end
        wr(6'h1d, 16'hffff);
        rd(6'h1d, d);
        chk("unmapped", d, 16'h0000);
        wr(6'h00, 16'h0303);
        wr(6'h20, 16'h0001);
        #1 chk("lock_out", pin_cfg_lock, 32'h1);
        wr(6'h00, 16'h0505);
        rd(6'h00, d);
        chk("locked_wr", d, 16'h0303);
        wr(6'h1c, ~wv);
        rd(6'h1c, d);
        chk("locked_out", d, wv & 16'h1f1f);
        wr(6'h20, 16'h0000);
        wr(6'h00, 16'h0505);
        rd(6'h00, d);
        chk("unlocked_wr", d, 16'h0505);
        report_and_stop();
    end
endmodule
`default_nettype wire
